// ### ieap_core.sv
// Interrupt entry, return and vector selection sequencer
// Behaviour
// - Entry pushes low PC byte first, condition byte last; pointer ends below.
// - Saved PC is the next main-program instruction address.
// - Index high byte is never part of the saved frame.
// - Return pops in reverse order then fetches three program bytes.
// - Enabled pin is watched by clocked edge or edge-and-level logic.
// - Enabled pin wakes the device in stop mode without clocks.
// - Pin detection only while pin enable equals one.
// - Configuration picks polarity, sensing mode, and interrupt or poll only.
// - Rising polarity turns the internal pull device into a pulldown.
// - Pin level visible to branch-on-pin-level instructions.
// - Edge-and-level flag sets on edge, stays set while pin asserted.
// - Vector high byte at first address, low byte at next.
// - Lower vector number has higher priority; highest pending served first.
// - Event sets flag; request only with local enable set.
// - Mask clear: finish instruction, push five bytes, set mask, fetch vector.
// - Fixed assignment of vectors one to twenty-two.
// - Vectors twenty-three to thirty-one stay unassigned.
// - Global mask set after reset.
// - Polarity zero falling or low, one rising or high.
// - Pull disable bit switches off internal pull device.
`timescale 1ns/1ps
module ieap_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Core status
    input wire logic instr_done,
    input wire logic [15:0] next_pc,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] index_low_in,
    input wire logic [7:0] ccr_in,
    input wire logic ccr_load,
    input wire logic swi_req,
    input wire logic rti_req,
    // Peripheral sources, index equals vector number
    input wire logic [31:0] src_flag,
    input wire logic [31:0] src_enable,
    // External pin
    input wire logic pin_in,
    input wire ieap_pkg::ieap_pin_cfg_s pin_cfg,
    input wire logic pin_flag_clear,
    input wire logic stop_mode,
    // Memory bus
    output logic mem_read,
    output logic mem_write,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Results
    output logic [15:0] pc_out,
    output logic [7:0] sp_out,
    output logic [7:0] ccr_out,
    output logic [7:0] acc_out,
    output logic [7:0] index_low_out,
    output logic busy,
    output logic irq_pending,
    output logic [4:0] active_vector,
    output logic pin_request_flag,
    output logic branch_if_pin_high,
    output logic branch_if_pin_low,
    output logic pin_wake,
    output logic pull_enable,
    output logic pull_down
);
    ieap_pkg::ieap_state_e state_reg;
    ieap_pkg::ieap_state_e state_next;
    ieap_pkg::ieap_frame_s frame_reg;
    logic [7:0] sp_reg;
    logic [7:0] ccr_reg;
    logic [15:0] pc_reg;
    logic [2:0] cnt_reg;
    logic [4:0] vec_reg;
    logic [31:0] req;
    logic [4:0] win_vec;
    logic win_found;
    logic pin_level;
    logic take_irq;
    logic [15:0] vec_addr;
    logic [7:0] push_byte;
    logic [7:0] pop_addr;
    logic [7:0] push_addr;

    ieap_pin_detect u_pin (
        .mclk(mclk),
        .rst(rst),
        .pin_in(pin_in),
        .cfg(pin_cfg),
        .stop_mode(stop_mode),
        .flag_clear(pin_flag_clear),
        .pin_request_flag(pin_request_flag),
        .pin_level(pin_level),
        .pin_wake(pin_wake),
        .pull_enable(pull_enable),
        .pull_down(pull_down)
    );

    // Request vector: pin flag poll only unless its enable is set
    genvar gi;
    generate
        for (gi = 0; gi < ieap_pkg::NUM_VEC; gi++) begin : g_req
            if (gi == ieap_pkg::VEC_PIN) begin : g_pin
                assign req[gi] = pin_request_flag &
                    pin_cfg.pin_request_irq_enable;
            end else if (gi >= ieap_pkg::VEC_FIRST_HW &&
                gi <= ieap_pkg::VEC_LAST_HW) begin : g_hw
                assign req[gi] = src_flag[gi] & src_enable[gi];
            end else begin : g_none
                assign req[gi] = 1'b0;
            end
        end
    endgenerate

    // Lowest number wins
    always_comb begin
        win_vec = 5'h00;
        win_found = 1'b0;
        for (int i = ieap_pkg::NUM_VEC - 1; i >= 1; i--) begin
            if (req[i]) begin
                win_vec = 5'(i);
                win_found = 1'b1;
            end
        end
    end

    assign irq_pending = win_found;
    assign take_irq = instr_done & win_found &
        ~ccr_reg[ieap_pkg::CCR_MASK_BIT];
    assign vec_addr = ieap_pkg::VEC_TOP - {10'h000, vec_reg, 1'b0};
    // Push order: PROG_COUNTER_LOW, PROG_COUNTER_HIGH, X, A, CONDITION_CODE_BYTE; index high never included
    assign push_byte = (cnt_reg == 3'h0) ? frame_reg.prog_counter_low :
        (cnt_reg == 3'h1) ? frame_reg.prog_counter_high :
        (cnt_reg == 3'h2) ? frame_reg.x_reg :
        (cnt_reg == 3'h3) ? frame_reg.a_reg :
        frame_reg.condition_code_byte;
    assign push_addr = sp_reg;
    assign pop_addr = sp_reg + 8'h01;
    assign branch_if_pin_high = pin_cfg.pin_request_enable & pin_level;
    assign branch_if_pin_low = pin_cfg.pin_request_enable & ~pin_level;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ieap_pkg::IEAP_IDLE: begin
                if (take_irq || (instr_done && swi_req)) begin
                    state_next = ieap_pkg::IEAP_PUSH;
                end else if (instr_done && rti_req) begin
                    state_next = ieap_pkg::IEAP_POP;
                end
            end
            ieap_pkg::IEAP_PUSH: begin
                if (cnt_reg == ieap_pkg::FRAME_BYTES - 3'h1) begin
                    state_next = ieap_pkg::IEAP_VECH;
                end
            end
            ieap_pkg::IEAP_VECH: state_next = ieap_pkg::IEAP_VECL;
            ieap_pkg::IEAP_VECL: state_next = ieap_pkg::IEAP_FILL;
            ieap_pkg::IEAP_POP: begin
                if (cnt_reg == ieap_pkg::FRAME_BYTES - 3'h1) begin
                    state_next = ieap_pkg::IEAP_FILL;
                end
            end
            ieap_pkg::IEAP_FILL: begin
                if (cnt_reg == {1'b0, ieap_pkg::FILL_BYTES} - 3'h1) begin
                    state_next = ieap_pkg::IEAP_IDLE;
                end
            end
            default: state_next = ieap_pkg::IEAP_IDLE;
        endcase
    end

    // Memory strobes
    assign mem_write = (state_reg == ieap_pkg::IEAP_PUSH);
    assign mem_read = (state_reg == ieap_pkg::IEAP_VECH) ||
        (state_reg == ieap_pkg::IEAP_VECL) ||
        (state_reg == ieap_pkg::IEAP_POP) ||
        (state_reg == ieap_pkg::IEAP_FILL);
    assign mem_wdata = push_byte;
    assign mem_addr =
        (state_reg == ieap_pkg::IEAP_PUSH) ? {8'h00, push_addr} :
        (state_reg == ieap_pkg::IEAP_VECH) ? vec_addr :
        (state_reg == ieap_pkg::IEAP_VECL) ? vec_addr + 16'h0001 :
        (state_reg == ieap_pkg::IEAP_POP) ? {8'h00, pop_addr} :
        (state_reg == ieap_pkg::IEAP_FILL) ? pc_reg + {13'h0000, cnt_reg} :
        16'h0000;

    assign busy = (state_reg != ieap_pkg::IEAP_IDLE);
    assign pc_out = pc_reg;
    assign sp_out = sp_reg;
    assign ccr_out = ccr_reg;
    assign acc_out = frame_reg.a_reg;
    assign index_low_out = frame_reg.x_reg;
    assign active_vector = vec_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= ieap_pkg::IEAP_IDLE;
            sp_reg <= ieap_pkg::SP_RESET;
            ccr_reg <= ieap_pkg::CCR_RESET;
            pc_reg <= 16'h0000;
            cnt_reg <= 3'h0;
            vec_reg <= 5'h00;
            frame_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= (state_next != state_reg) ? 3'h0 : cnt_reg + 3'h1;
            case (state_reg)
                ieap_pkg::IEAP_IDLE: begin
                    if (ccr_load) begin
                        ccr_reg <= ccr_in;
                    end
                    if (state_next == ieap_pkg::IEAP_PUSH) begin
                        // Saved PC is the instruction that would run next
                        frame_reg <= {next_pc, index_low_in, acc_in,
                            ccr_reg};
                        vec_reg <= take_irq ? win_vec :
                            ieap_pkg::VEC_SWI;
                    end
                end
                ieap_pkg::IEAP_PUSH: begin
                    sp_reg <= sp_reg - 8'h01;
                    if (state_next == ieap_pkg::IEAP_VECH) begin
                        ccr_reg[ieap_pkg::CCR_MASK_BIT] <= 1'b1;
                    end
                end
                ieap_pkg::IEAP_VECH: pc_reg[15:8] <= mem_rdata;
                ieap_pkg::IEAP_VECL: pc_reg[7:0] <= mem_rdata;
                ieap_pkg::IEAP_POP: begin
                    sp_reg <= pop_addr;
                    // Reverse order: CONDITION_CODE_BYTE, A, X, PROG_COUNTER_HIGH, PROG_COUNTER_LOW
                    if (cnt_reg == 3'h0) begin
                        ccr_reg <= mem_rdata;
                    end else if (cnt_reg == 3'h1) begin
                        frame_reg.a_reg <= mem_rdata;
                    end else if (cnt_reg == 3'h2) begin
                        frame_reg.x_reg <= mem_rdata;
                    end else if (cnt_reg == 3'h3) begin
                        pc_reg[15:8] <= mem_rdata;
                    end else begin
                        pc_reg[7:0] <= mem_rdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end
endmodule : ieap_core

// ### ieap_pkg.sv
// Package for the interrupt entry and external pin block
package ieap_pkg;
    localparam int NUM_VEC = 32;
    localparam logic [15:0] VEC_BASE = 16'hffc0;
    localparam logic [15:0] VEC_TOP = 16'hfffe;
    localparam logic [4:0] VEC_SWI = 5'h01;
    localparam logic [4:0] VEC_PIN = 5'h02;
    localparam logic [4:0] VEC_FIRST_HW = 5'h03;
    localparam logic [4:0] VEC_LAST_HW = 5'h16;
    localparam logic [4:0] VEC_FIRST_USER = 5'h17;
    localparam logic [7:0] SP_RESET = 8'hff;
    localparam logic [1:0] FILL_BYTES = 2'h3;
    localparam logic [2:0] FRAME_BYTES = 3'h5;
    localparam logic [7:0] CCR_RESET = 8'h08;
    localparam int CCR_MASK_BIT = 3;

    typedef enum logic [3:0] {
        IEAP_IDLE = 4'b0000,
        IEAP_PUSH = 4'b0001,
        IEAP_VECH = 4'b0010,
        IEAP_VECL = 4'b0011,
        IEAP_FILL = 4'b0100,
        IEAP_POP = 4'b0101,
        IEAP_RUN = 4'b0110
    } ieap_state_e;

    typedef struct packed {
        logic pin_request_enable;
        logic pin_polarity_select;
        logic edge_level_mode_select;
        logic pin_request_irq_enable;
        logic pin_pull_disable;
    } ieap_pin_cfg_s;

    typedef struct packed {
        logic [7:0] prog_counter_high;
        logic [7:0] prog_counter_low;
        logic [7:0] x_reg;
        logic [7:0] a_reg;
        logic [7:0] condition_code_byte;
    } ieap_frame_s;
endpackage : ieap_pkg

// ### ieap_pin_detect.sv
// External request pin detector with synchroniser and async wake path
`timescale 1ns/1ps
module ieap_pin_detect (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Pin and configuration
    input wire logic pin_in,
    input wire ieap_pkg::ieap_pin_cfg_s cfg,
    input wire logic stop_mode,
    input wire logic flag_clear,
    // Status
    output logic pin_request_flag,
    output logic pin_level,
    output logic pin_wake,
    output logic pull_enable,
    output logic pull_down
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic flag_reg;
    logic asserted;
    logic edge_seen;
    logic level_hold;
    logic flag_next;

    assign asserted = cfg.pin_request_enable &
        (sync2_reg ~^ cfg.pin_polarity_select);
    assign edge_seen = asserted & ~prev_reg;
    assign level_hold = asserted & cfg.edge_level_mode_select;
    assign flag_next = edge_seen | level_hold |
        (flag_reg & ~flag_clear);
    // Raw pin combined with enable, polarity and stop mode only: no clock needed while stopped
    assign pin_wake = stop_mode & cfg.pin_request_enable &
        (pin_in ~^ cfg.pin_polarity_select);
    assign pin_request_flag = flag_reg;
    assign pin_level = sync2_reg;
    assign pull_enable = cfg.pin_request_enable & ~cfg.pin_pull_disable;
    assign pull_down = cfg.pin_polarity_select;

    always_ff @(posedge mclk) begin
        sync1_reg <= pin_in;
        sync2_reg <= sync1_reg;
        if (rst) begin
            prev_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            prev_reg <= asserted;
            flag_reg <= cfg.pin_request_enable & flag_next;
        end
    end
endmodule : ieap_pin_detect

// ### ieap_core_sva.sv
// Checker for the interrupt entry and pin block
`timescale 1ns/1ps
module ieap_core_sva (
    // Clock, reset and core requests
    input logic mclk,
    input logic rst,
    input logic instr_done,
    input logic swi_req,
    input logic rti_req,
    input logic [15:0] next_pc,
    input logic [7:0] index_low_in,
    // Pin
    input logic pin_in,
    input ieap_pkg::ieap_pin_cfg_s pin_cfg,
    // Memory bus
    input logic mem_read,
    input logic mem_write,
    input logic [15:0] mem_addr,
    input logic [7:0] mem_wdata,
    input logic [7:0] mem_rdata,
    // Results
    input logic [7:0] sp_out,
    input logic [7:0] ccr_out,
    input logic busy,
    input logic irq_pending,
    input logic pin_request_flag,
    input logic pull_enable,
    input logic pull_down,
    input logic branch_if_pin_high,
    input logic branch_if_pin_low,
    input logic [4:0] active_vector
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire take_in = !busy && instr_done &&
        (swi_req || (irq_pending && !ccr_out[ieap_pkg::CCR_MASK_BIT]));
    wire take_out = !busy && instr_done && rti_req && !take_in;
    wire [7:0] pc_lo = next_pc[7:0];
    wire [7:0] pc_hi = next_pc[15:8];
    wire en = pin_cfg.pin_request_enable;
    wire pol = pin_cfg.pin_polarity_select;
    sequence s_push;
        mem_write && mem_addr == {8'h00, $past(sp_out)} &&
        mem_wdata == $past(pc_lo) ##1
        (mem_write && mem_addr == $past(mem_addr) - 16'h0001) [*4];
    endsequence
    sequence s_fill;
        mem_read && mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)}
        ##1 (mem_read && mem_addr == $past(mem_addr) + 16'h0001) [*2];
    endsequence
    sequence s_vec;
        mem_read &&
        mem_addr == ieap_pkg::VEC_TOP - {10'h000, active_vector, 1'h0}
        ##1 mem_read && mem_addr == $past(mem_addr) + 16'h0001 ##1 s_fill;
    endsequence
    sequence s_pop;
        mem_read && mem_addr == {8'h00, $past(sp_out) + 8'h01}
        ##1 (mem_read && mem_addr == $past(mem_addr) + 16'h0001) [*4];
    endsequence
    a_push_frame: assert property (take_in |=> s_push ##1 !mem_write)
        else $error("entry push order wrong");
    a_frame_data: assert property (take_in |-> ##2
        mem_wdata == $past(pc_hi, 2) ##1 mem_wdata == $past(index_low_in, 3)
        ##2 mem_wdata == $past(ccr_out, 5)) else $error("frame data wrong");
    a_mask_sp: assert property (take_in |-> ##8
        ccr_out[ieap_pkg::CCR_MASK_BIT] ##2
        sp_out == $past(sp_out, 10) - 8'h05) else $error("entry end");
    a_vec_fetch: assert property (take_in |-> ##6 s_vec)
        else $error("vector fetch wrong");
    a_ret_pop: assert property (take_out |=> s_pop ##1 s_fill)
        else $error("return sequence wrong");
    a_pull_ctrl: assert property (en |-> pull_down == pol &&
        pull_enable == !pin_cfg.pin_pull_disable) else $error("pull wrong");
    a_pin_level: assert property (en && !$past(rst) && !$past(rst, 2)
        |-> branch_if_pin_high == $past(pin_in, 2) &&
        branch_if_pin_low != $past(pin_in, 2)) else $error("pin level");
    a_pin_event: assert property (en && $past(pin_in, 3) != pol &&
        $past(pin_in, 2) == pol && $past(pin_in) == pol
        |-> ##[0:2] pin_request_flag) else $error("pin edge missed");
    a_level_hold: assert property (pin_request_flag && en &&
        pin_cfg.edge_level_mode_select && $past(pin_in) == pol &&
        $past(pin_in, 2) == pol |=> pin_request_flag) else $error("hold");
    a_pin_off: assert property (!en && !pin_request_flag
        |=> !pin_request_flag) else $error("flag set while disabled");
endmodule : ieap_core_sva
bind ieap_core ieap_core_sva ieap_core_sva_inst (.mclk, .rst, .instr_done,
    .swi_req, .rti_req, .next_pc, .index_low_in, .pin_in, .pin_cfg,
    .mem_read, .mem_write, .mem_addr, .mem_wdata, .mem_rdata, .sp_out,
    .ccr_out, .busy, .irq_pending, .pin_request_flag, .pull_enable,
    .pull_down, .branch_if_pin_high, .branch_if_pin_low, .active_vector);

// ### ieap_mem_model.sv
// Memory model answering stack, vector and program reads
`timescale 1ns/1ps
module ieap_mem_model (
    // Clock
    input logic mclk,
    // Memory bus
    input logic mem_read,
    input logic mem_write,
    input logic [15:0] mem_addr,
    input logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] stk [0:255];
    logic [7:0] val;
    always_ff @(posedge mclk) begin
        if (mem_write) begin
            stk[mem_addr[7:0]] <= mem_wdata;
        end
    end
    // Vector n holds handler {3'b100, n, 8'h00}, high byte first
    always_comb begin
        if (mem_addr >= ieap_pkg::VEC_BASE) begin
            val = mem_addr[0] ? 8'h00 : {3'h4, ~mem_addr[5:1]};
        end else if (mem_addr[15:8] == 8'h00) begin
            val = stk[mem_addr[7:0]];
        end else begin
            val = mem_addr[7:0] ^ 8'h5a;
        end
    end
    // Unselected bus shows a changing pattern
    assign mem_rdata = mem_read ? val : ~val;
endmodule : ieap_mem_model

// ### interrupt_entry_and_ext_pin_tb_top.sv
// Bench for the interrupt entry and pin block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
$display("[ERR] %0t got %h want %h", $time, a, b); end end
module interrupt_entry_and_ext_pin_tb_top;
    logic mclk, rst, instr_done, ccr_load, swi_req, rti_req, pin_in;
    logic pin_flag_clear, stop_mode, mem_read, mem_write, busy, pull_down;
    logic irq_pending, pin_request_flag, branch_if_pin_high, pin_wake;
    logic branch_if_pin_low, pull_enable;
    logic [15:0] next_pc, mem_addr, pc_out;
    logic [7:0] acc_in, index_low_in, ccr_in, mem_wdata, mem_rdata, sp_out;
    logic [7:0] ccr_out, acc_out, index_low_out;
    logic [31:0] src_flag, src_enable;
    logic [4:0] active_vector;
    ieap_pkg::ieap_pin_cfg_s pin_cfg;
    int err_total = 0;
    int num_checks = 0;
    ieap_core ieap_core_inst (.mclk, .rst, .instr_done, .next_pc, .acc_in,
        .index_low_in, .ccr_in, .ccr_load, .swi_req, .rti_req, .src_flag,
        .src_enable, .pin_in, .pin_cfg, .pin_flag_clear, .stop_mode,
        .mem_read, .mem_write, .mem_addr, .mem_wdata, .mem_rdata, .pc_out,
        .sp_out, .ccr_out, .acc_out, .index_low_out, .busy, .irq_pending,
        .active_vector, .pin_request_flag, .branch_if_pin_high,
        .branch_if_pin_low, .pin_wake, .pull_enable, .pull_down);
    ieap_mem_model ieap_mem_model_inst (.mclk, .mem_read, .mem_write,
        .mem_addr, .mem_wdata, .mem_rdata);
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic req(input logic s, input logic r);
        {instr_done, swi_req, rti_req} = {1'h1, s, r};
        step(1);
        {instr_done, swi_req, rti_req} = 3'h0;
        for (int i = 0; i < 40 && busy !== 1'h0; i++) step(1);
    endtask : req
    task automatic clr;
        pin_flag_clear = 1'h1;
        step(1);
        pin_flag_clear = 1'h0;
    endtask : clr
    task automatic t_swi;
        logic [39:0] fr;
        {next_pc, acc_in, index_low_in} = 32'h1234_a1b2;
        req(1'h1, 1'h0);
        fr = {ieap_mem_model_inst.stk[8'hff], ieap_mem_model_inst.stk[8'hfe],
            ieap_mem_model_inst.stk[8'hfd], ieap_mem_model_inst.stk[8'hfc],
            ieap_mem_model_inst.stk[8'hfb]};
        `CHK(fr, 40'h3412_b2a1_08)
        `CHK(({sp_out, active_vector}), 13'h1f41)
        `CHK(pc_out, 16'h8100)
        {acc_in, index_low_in} = 16'h0000;
        req(1'h0, 1'h1);
        `CHK(({acc_out, index_low_out, ccr_out, sp_out}), 32'ha1b2_08ff)
        `CHK(pc_out, 16'h1234)
    endtask : t_swi
    task automatic t_irq;
        {src_flag, src_enable} = {32'h0080_0228, 32'h0080_0220};
        req(1'h0, 1'h0);
        `CHK(sp_out, 8'hff)
        `CHK(irq_pending, 1'h1)
        {ccr_in, ccr_load} = 9'h001;
        step(1);
        ccr_load = 1'h0;
        req(1'h0, 1'h0);
        `CHK(active_vector, 5'h05)
        `CHK(ieap_mem_model_inst.stk[8'hfb], 8'h00)
        src_flag[5] = 1'h0;
        req(1'h0, 1'h1);
        req(1'h0, 1'h0);
        `CHK(active_vector, 5'h09)
        src_flag = 32'h0080_0008;
        req(1'h0, 1'h1);
        `CHK(ccr_out, 8'h00)
        req(1'h0, 1'h0);
        `CHK(sp_out, 8'hff)
        src_flag = 32'h0000_0000;
    endtask : t_irq
    task automatic t_pin;
        pin_cfg = 5'h1c;
        step(1);
        `CHK(({pull_enable, pull_down}), 2'h3)
        pin_cfg.pin_pull_disable = 1'h1;
        step(1);
        `CHK(pull_enable, 1'h0)
        pin_in = 1'h1;
        step(4);
        `CHK(({pin_request_flag, branch_if_pin_high}), 2'h3)
        clr();
        `CHK(pin_request_flag, 1'h1)
        pin_in = 1'h0;
        step(4);
        clr();
        `CHK(({pin_request_flag, branch_if_pin_low}), 2'h1)
        pin_cfg = 5'h10;
        pin_in = 1'h1;
        step(4);
        clr();
        pin_in = 1'h0;
        step(4);
        `CHK(pin_request_flag, 1'h1)
        clr();
        `CHK(pin_request_flag, 1'h0)
        pin_cfg = 5'h00;
        pin_in = 1'h1;
        step(4);
        pin_in = 1'h0;
        step(4);
        `CHK(pin_request_flag, 1'h0)
        {pin_cfg, stop_mode, pin_in} = 7'h63;
        step(1);
        `CHK(pin_wake, 1'h1)
        {stop_mode, pin_in} = 2'h0;
        step(4);
        `CHK(pin_wake, 1'h0)
        clr();
        pin_cfg = 5'h1a;
        pin_in = 1'h1;
        step(4);
        req(1'h0, 1'h0);
        `CHK(active_vector, ieap_pkg::VEC_PIN)
        clr();
        req(1'h0, 1'h1);
    endtask : t_pin
    initial begin
        {rst, instr_done, ccr_load, swi_req, rti_req} = 5'h10;
        {pin_in, pin_flag_clear, stop_mode, pin_cfg} = 8'h00;
        {next_pc, acc_in, index_low_in, ccr_in} = 40'h0;
        {src_flag, src_enable} = 64'h0;
        step(16);
        rst = 1'h0;
        `CHK(({sp_out, ccr_out}), 16'hff08)
        step(1);
        t_swi();
        t_irq();
        t_pin();
        end_sim();
    end
endmodule : interrupt_entry_and_ext_pin_tb_top
